/* File: verif/link_mode_resolver_tb_top.sv */
// Purpose: self-checking bench of the link mode resolver
// Assumes: baud divider shortened to 4 cycles
// Notes:   sweeps every mode pair, then random pairs
`timescale 1ns/1ps
module link_mode_resolver_tb_top;
  logic clock, reset_n, psel, penable, pwrite, video, lead;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, link_ack, tick, rack;
  logic [2:0] rmode;
  logic [1:0] ack_dly;
  link_mode_pkg::mode_e want, status;
  link_mode_pkg::mode_prop_s rprop, lprop;
  link_mode_pkg::traffic_en_s traffic;
  integer fail_count, checks, seed, i, n;
  link_mode_resolver #(.BAUD_DIV(4)) i_dut (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .REMOTE_MODE(rmode), .REMOTE_VIDEO(video),
    .REMOTE_PROP(rprop), .REMOTE_ACK(rack), .LINK_PROP(lprop), .LINK_ACK(link_ack),
    .MODE_STATUS(status), .TRAFFIC_EN(traffic), .SERIAL_TICK(tick));
  remote_end_model i_far (.clk(clock), .rst_n(reset_n), .lead(lead), .want(want), .cur(status),
    .link_prop(lprop), .link_ack(link_ack), .ack_dly(ack_dly), .remote_prop(rprop), .remote_ack(rack));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task final_report;
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // data and error are taken at the very edge that sees ready
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      final_report();
    end
  endtask : apb
  function automatic link_mode_pkg::mode_e xmode(input logic [2:0] l, r, input logic v, lp);
    if (l == 3'h3 || r == 3'h3) return link_mode_pkg::MODE_SERIAL_ONLY_LP;
    if (l == 3'h4 || r == 3'h4) return link_mode_pkg::MODE_SERIAL_NET_LP;
    if (l == 3'h0 && r == 3'h0)
      return v ? link_mode_pkg::MODE_FULL_BANDWIDTH :
        (lp ? link_mode_pkg::MODE_SERIAL_ONLY_LP : link_mode_pkg::MODE_SERIAL_NET_LP);
    if (l == 3'h2 || r == 3'h2) return link_mode_pkg::MODE_LONG_REACH;
    return link_mode_pkg::MODE_FULL_BANDWIDTH;
  endfunction : xmode
  function automatic logic [4:0] xtraffic(input link_mode_pkg::mode_e m);
    if (m == link_mode_pkg::MODE_SERIAL_ONLY_LP) return 5'h01;
    if (m == link_mode_pkg::MODE_SERIAL_NET_LP) return 5'h05;
    return 5'h1f;
  endfunction : xtraffic
  task run_cfg(input logic [2:0] l, r, input logic v, lp);
    link_mode_pkg::mode_e e;
    e = xmode(l, r, v, lp);
    @(posedge clock);
    rmode <= r;
    video <= v;
    lead <= (l == 3'h0);
    want <= (r == 3'h0) ? e : link_mode_pkg::mode_e'(r);
    ack_dly <= 2'($random(seed));
    apb(1'b1, link_mode_pkg::REG_CFG, {28'h0, lp, l});
    n = 0;
    while (status !== e && n < 80)
    begin
      @(negedge clock);
      n++;
    end
    if (status !== e)
    begin
      fail_count++;
      final_report();
    end
    chk(status, e);
    chk(traffic, xtraffic(e));
    apb(1'b0, link_mode_pkg::REG_STATUS, 32'h0);
    // far-end codes above 4 read back as automatic
    chk({rd[14:12], rd[8], rd[6:4], rd[2:0]}, {3'h1, v, (r > 3'h4) ? 3'h0 : r, e});
  endtask : run_cfg
  initial
  begin
    {psel, penable, pwrite, video, lead} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rmode = 3'h0;
    ack_dly = 2'h0;
    want = link_mode_pkg::MODE_SERIAL_ONLY_LP;
    fail_count = 0;
    checks = 0;
    seed = 84570;
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk(status, link_mode_pkg::MODE_SERIAL_ONLY_LP);
    chk(traffic, 5'h01);
    apb(1'b0, link_mode_pkg::REG_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (i = 0; i < 25; i++)
      run_cfg(3'(i / 5), 3'(i % 5), 1'b1, 1'b0);
    run_cfg(3'h2, 3'h6, 1'b0, 1'b0);
    run_cfg(3'h0, 3'h0, 1'b0, 1'b1);
    run_cfg(3'h0, 3'h0, 1'b0, 1'b0);
    // start from clear flags so the refusal below is really seen
    apb(1'b1, link_mode_pkg::REG_FLAGS, 32'h3);
    apb(1'b0, link_mode_pkg::REG_FLAGS, 32'h0);
    chk(rd[1:0], 2'h0);
    @(posedge clock);
    want <= link_mode_pkg::MODE_LONG_REACH;
    repeat (6) @(posedge clock);
    apb(1'b0, link_mode_pkg::REG_FLAGS, 32'h0);
    chk({rd[0], status}, {1'b1, link_mode_pkg::MODE_SERIAL_NET_LP});
    // clear while refusals repeat: the new event must win
    apb(1'b1, link_mode_pkg::REG_FLAGS, 32'h3);
    apb(1'b0, link_mode_pkg::REG_FLAGS, 32'h0);
    chk(rd[0], 1'b1);
    run_cfg(3'h3, 3'h3, 1'b0, 1'b0);
    for (i = 0; i < 2; i++)
    begin
      n = 0;
      do
      begin
        @(negedge clock);
        n++;
      end
      while (tick !== 1'b1 && n < 20);
      if (tick !== 1'b1)
      begin
        fail_count++;
        final_report();
      end
    end
    chk(n, 4);
    for (i = 0; i < 30; i++)
      run_cfg(3'($unsigned($random(seed)) % 5), 3'($unsigned($random(seed)) % 5),
        1'($random(seed)), 1'($random(seed)));
    final_report();
  end
endmodule : link_mode_resolver_tb_top

/* File: verif/remote_end_model.sv */
// Purpose: far-end transmitter logic model
// Assumes: same clock and reset as the resolver
// Notes:   proposes only while it leads; acks after a set delay
`timescale 1ns/1ps
module remote_end_model (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 lead,
  input  link_mode_pkg::mode_e      want,
  input  link_mode_pkg::mode_e      cur,
  input  link_mode_pkg::mode_prop_s link_prop,
  input  wire logic                 link_ack,
  input  wire logic [1:0]           ack_dly,
  output link_mode_pkg::mode_prop_s remote_prop,
  output logic                      remote_ack
);
  logic [1:0] cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remote_prop <= '0;
      remote_ack  <= 1'b0;
      cnt         <= 2'h0;
    end
    else
    begin
      // hold until acked; released mode shows garbage, not the last value
      if (link_ack || !lead || want == cur)
      begin
        remote_prop.valid <= 1'b0;
        remote_prop.mode  <= link_mode_pkg::mode_e'(~want);
      end
      else
        remote_prop <= {1'b1, want};
      if (link_prop.valid && !remote_ack && cnt == ack_dly)
      begin
        remote_ack <= 1'b1;
        cnt        <= 2'h0;
      end
      else
      begin
        remote_ack <= 1'b0;
        cnt        <= (link_prop.valid && !remote_ack) ? cnt + 2'h1 : 2'h0;
      end
    end
  end
endmodule : remote_end_model

/* File: verilog/change_watch.sv */
// Purpose: one-cycle pulse whenever a watched vector changes
// Assumes: vector synchronous to clk
// Notes:   comparison is against last cycle's value
`timescale 1ns/1ps
module change_watch #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] value,
  output logic              changed
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  if (W < 1)
  begin : g_chk
    $error("change_watch: W must be at least 1");
  end

  always_comb
  begin
    prev_d  = value;
    changed = (value != prev_q);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= '0;
    else
      prev_q <= prev_d;
  end

endmodule : change_watch

/* File: verilog/link_mode_pkg.sv */
// Purpose: shared types and constants of the link mode resolver
// Assumes: 10 MHz core clock, APB register access
// Notes:   mode codes are shared with the far-end link logic
package link_mode_pkg;

  typedef enum logic [2:0] {
    MODE_AUTO           = 3'h0,
    MODE_FULL_BANDWIDTH = 3'h1,
    MODE_LONG_REACH     = 3'h2,
    MODE_SERIAL_ONLY_LP = 3'h3,
    MODE_SERIAL_NET_LP  = 3'h4
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_PROPOSE = 3'h2,
    ST_ACK     = 3'h4
  } neg_state_e;

  typedef struct packed {
    logic  valid;
    mode_e mode;
  } mode_prop_s;

  typedef struct packed {
    logic video;
    logic audio;
    logic network;
    logic infrared;
    logic serial;
  } traffic_en_s;

  // register byte offsets
  localparam logic [11:0] REG_CFG    = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FLAGS  = 12'h008;

  // field positions
  localparam int CFG_MODE_LSB      = 0;
  localparam int CFG_LP_SEL_BIT    = 3;
  localparam int STAT_RES_LSB      = 0;
  localparam int STAT_REM_LSB      = 4;
  localparam int STAT_VIDEO_BIT    = 8;
  localparam int STAT_STATE_LSB    = 12;
  localparam int FLAG_REFUSED_BIT  = 0;
  localparam int FLAG_CHANGED_BIT  = 1;

  // values after reset
  localparam mode_e CFG_MODE_RST   = MODE_AUTO;
  localparam logic  CFG_LP_SEL_RST = 1'b0;
  localparam mode_e RESOLVED_RST   = MODE_SERIAL_ONLY_LP;

  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SERIAL_BAUD     = 9600;
  localparam int BAUD_DIV_CYCLES = 1_000_000_000 / (CLK_PERIOD_NS * SERIAL_BAUD);

endpackage : link_mode_pkg

/* File: verilog/link_mode_resolver.sv */
// Purpose: resolve and negotiate the twisted-pair link mode, receiver end
// Assumes: far-end transmitter logic on the same clock
// Notes:   registers over APB, one wait-free access phase
//
// Contract
// - link mode depends on both ends' configured modes, never local alone.
// - five settings per end; automatic lets logic choose the mode.
// - serial-only low power carries only 9600 baud serial.
// - serial-plus-network low power carries 9600 baud serial and network.
// - any serial-only end wins; else any serial-network end wins.
// - no low power: full+full full, long anywhere long, auto adopts manual.
// - both automatic with video present settles in full bandwidth.
// - both automatic without video moves to a low-power partial mode.
// - both automatic never yields long reach.
// - both automatic, every transition is negotiated, never unilateral.
// - manual end initiates negotiation when the other is automatic.
// - automatic end follows the manual end's proposal.
`timescale 1ns/1ps
module link_mode_resolver #(
  parameter int BAUD_DIV = link_mode_pkg::BAUD_DIV_CYCLES
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic [2:0]            REMOTE_MODE,
  input  wire logic                  REMOTE_VIDEO,
  input  link_mode_pkg::mode_prop_s  REMOTE_PROP,
  input  wire logic                  REMOTE_ACK,
  output link_mode_pkg::mode_prop_s  LINK_PROP,
  output logic                       LINK_ACK,
  output link_mode_pkg::mode_e       MODE_STATUS,
  output link_mode_pkg::traffic_en_s TRAFFIC_EN,
  output logic                       SERIAL_TICK
);

  if (BAUD_DIV < 2 || BAUD_DIV > 65535)
  begin : g_chk
    $error("link_mode_resolver: BAUD_DIV out of range");
  end

  link_mode_pkg::mode_e       loc_mode_q;
  link_mode_pkg::mode_e       loc_mode_d;
  logic                       lp_sel_q;
  logic                       lp_sel_d;
  link_mode_pkg::mode_e       rem_mode;
  link_mode_pkg::mode_e       target;
  logic                       changed;
  link_mode_pkg::neg_state_e  st_q;
  link_mode_pkg::neg_state_e  st_d;
  link_mode_pkg::mode_e       cur_q;
  link_mode_pkg::mode_e       cur_d;
  link_mode_pkg::mode_e       prop_q;
  link_mode_pkg::mode_e       prop_d;
  logic                       ack_q;
  logic                       ack_d;
  logic                       pend_q;
  logic                       pend_d;
  logic                       refused_q;
  logic                       refused_d;
  logic                       chg_flag_q;
  logic                       chg_flag_d;
  logic                       refuse_evt;
  link_mode_pkg::traffic_en_s en_q;
  link_mode_pkg::traffic_en_s en_d;
  logic [15:0]                baud_cnt_q;
  logic [15:0]                baud_cnt_d;
  logic                       tick_q;
  logic                       tick_d;
  logic                       pready_q;
  logic                       pready_d;
  logic                       pslverr_q;
  logic                       pslverr_d;
  logic [31:0]                prdata_q;
  logic [31:0]                prdata_d;
  logic                       both_auto;
  logic                       both_manual;
  logic                       loc_leads;
  logic                       rem_leads;
  logic                       setup;
  logic                       wr_en;
  logic                       mapped;
  logic [31:0]                rd_mux;

  // unknown far-end codes are treated as automatic
  always_comb
  begin
    if (REMOTE_MODE <= 3'h4)
      rem_mode = link_mode_pkg::mode_e'(REMOTE_MODE);
    else
      rem_mode = link_mode_pkg::MODE_AUTO;
  end

  // both ends feed the resolution
  mode_table u_table (
    .loc_mode       (loc_mode_q),
    .rem_mode       (rem_mode),
    .video_present  (REMOTE_VIDEO),
    .lp_serial_only (lp_sel_q),
    .target         (target)
  );

  change_watch #(
    .W (8)
  ) u_watch (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .value   ({loc_mode_q, rem_mode, REMOTE_VIDEO, lp_sel_q}),
    .changed (changed)
  );

  always_comb
  begin
    both_auto   = loc_mode_q == link_mode_pkg::MODE_AUTO && rem_mode == link_mode_pkg::MODE_AUTO;
    both_manual = loc_mode_q != link_mode_pkg::MODE_AUTO && rem_mode != link_mode_pkg::MODE_AUTO;
    loc_leads   = loc_mode_q != link_mode_pkg::MODE_AUTO && rem_mode == link_mode_pkg::MODE_AUTO;
    rem_leads   = both_auto || (loc_mode_q == link_mode_pkg::MODE_AUTO && !both_manual);
  end

  function automatic link_mode_pkg::traffic_en_s traffic_for(input link_mode_pkg::mode_e m);
    link_mode_pkg::traffic_en_s t;
    t = '{video: 1'b1, audio: 1'b1, network: 1'b1, infrared: 1'b1, serial: 1'b1};
    if (m == link_mode_pkg::MODE_SERIAL_ONLY_LP)
      t = '{video: 1'b0, audio: 1'b0, network: 1'b0, infrared: 1'b0, serial: 1'b1};
    else if (m == link_mode_pkg::MODE_SERIAL_NET_LP)
      t = '{video: 1'b0, audio: 1'b0, network: 1'b1, infrared: 1'b0, serial: 1'b1};
    return t;
  endfunction : traffic_for

  // negotiation
  always_comb
  begin
    st_d       = st_q;
    cur_d      = cur_q;
    prop_d     = prop_q;
    ack_d      = 1'b0;
    pend_d     = pend_q | changed;
    refuse_evt = 1'b0;
    case (st_q)
      link_mode_pkg::ST_IDLE:
      begin
        if (REMOTE_PROP.valid)
        begin
          // far end leads; long reach refused when both automatic
          if (rem_leads && REMOTE_PROP.mode != link_mode_pkg::MODE_AUTO
              && REMOTE_PROP.mode <= link_mode_pkg::MODE_SERIAL_NET_LP
              && !(both_auto && REMOTE_PROP.mode == link_mode_pkg::MODE_LONG_REACH))
          begin
            cur_d = REMOTE_PROP.mode;
            ack_d = 1'b1;
            st_d  = link_mode_pkg::ST_ACK;
          end
          else
            refuse_evt = 1'b1;
        end
        else if (pend_q)
        begin
          pend_d = changed;
          if (target != cur_q)
          begin
            if (both_manual)
              cur_d = target;
            else if (loc_leads)
            begin
              prop_d = target;
              st_d   = link_mode_pkg::ST_PROPOSE;
            end
          end
        end
      end
      link_mode_pkg::ST_PROPOSE:
      begin
        if (REMOTE_ACK)
        begin
          cur_d = prop_q;
          st_d  = link_mode_pkg::ST_IDLE;
        end
        else if (changed)
        begin
          // configuration moved under us: withdraw and start over
          st_d   = link_mode_pkg::ST_IDLE;
          pend_d = 1'b1;
        end
      end
      link_mode_pkg::ST_ACK:
        st_d = link_mode_pkg::ST_IDLE;
      default:
        st_d = link_mode_pkg::ST_IDLE;
    endcase
    en_d = traffic_for(cur_d);
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q   <= link_mode_pkg::ST_IDLE;
      cur_q  <= link_mode_pkg::RESOLVED_RST;
      prop_q <= link_mode_pkg::RESOLVED_RST;
      ack_q  <= 1'b0;
      pend_q <= 1'b1;
      en_q   <= '{video: 1'b0, audio: 1'b0, network: 1'b0, infrared: 1'b0, serial: 1'b1};
    end
    else
    begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      prop_q <= prop_d;
      ack_q  <= ack_d;
      pend_q <= pend_d;
      en_q   <= en_d;
    end
  end

  // fixed serial rate tick, only while a low-power mode holds
  always_comb
  begin
    if (baud_cnt_q == 16'(BAUD_DIV - 1))
      baud_cnt_d = 16'h0000;
    else
      baud_cnt_d = baud_cnt_q + 16'h0001;
    tick_d = baud_cnt_q == 16'(BAUD_DIV - 1) && !en_q.video;
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // APB slave: read data captured in setup, ready in the first access cycle
  always_comb
  begin
    setup  = PSEL && !PENABLE;
    wr_en  = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    mapped = PADDR == link_mode_pkg::REG_CFG || PADDR == link_mode_pkg::REG_STATUS
             || PADDR == link_mode_pkg::REG_FLAGS;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      link_mode_pkg::REG_CFG:
      begin
        rd_mux[link_mode_pkg::CFG_MODE_LSB +: 3] = loc_mode_q;
        rd_mux[link_mode_pkg::CFG_LP_SEL_BIT]    = lp_sel_q;
      end
      link_mode_pkg::REG_STATUS:
      begin
        rd_mux[link_mode_pkg::STAT_RES_LSB +: 3]   = cur_q;
        rd_mux[link_mode_pkg::STAT_REM_LSB +: 3]   = rem_mode;
        rd_mux[link_mode_pkg::STAT_VIDEO_BIT]      = REMOTE_VIDEO;
        rd_mux[link_mode_pkg::STAT_STATE_LSB +: 3] = st_q;
      end
      link_mode_pkg::REG_FLAGS:
      begin
        rd_mux[link_mode_pkg::FLAG_REFUSED_BIT] = refused_q;
        rd_mux[link_mode_pkg::FLAG_CHANGED_BIT] = chg_flag_q;
      end
      default:
        rd_mux = 32'h0000_0000;
    endcase
    pready_d  = setup;
    pslverr_d = setup && !mapped;
    prdata_d  = (setup && !PWRITE) ? rd_mux : 32'h0000_0000;
    loc_mode_d = loc_mode_q;
    lp_sel_d   = lp_sel_q;
    if (wr_en && PADDR == link_mode_pkg::REG_CFG)
    begin
      // illegal mode codes are dropped, keeping the old setting
      if (PWDATA[link_mode_pkg::CFG_MODE_LSB +: 3] <= 3'h4)
        loc_mode_d = link_mode_pkg::mode_e'(PWDATA[link_mode_pkg::CFG_MODE_LSB +: 3]);
      lp_sel_d = PWDATA[link_mode_pkg::CFG_LP_SEL_BIT];
    end
    // write one to clear; a new event in the same cycle wins
    refused_d  = refuse_evt || (refused_q
                 && !(wr_en && PADDR == link_mode_pkg::REG_FLAGS && PWDATA[link_mode_pkg::FLAG_REFUSED_BIT]));
    chg_flag_d = (cur_d != cur_q) || (chg_flag_q
                 && !(wr_en && PADDR == link_mode_pkg::REG_FLAGS && PWDATA[link_mode_pkg::FLAG_CHANGED_BIT]));
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      loc_mode_q <= link_mode_pkg::CFG_MODE_RST;
      lp_sel_q   <= link_mode_pkg::CFG_LP_SEL_RST;
      refused_q  <= 1'b0;
      chg_flag_q <= 1'b0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
    end
    else
    begin
      loc_mode_q <= loc_mode_d;
      lp_sel_q   <= lp_sel_d;
      refused_q  <= refused_d;
      chg_flag_q <= chg_flag_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
    end
  end

  always_comb
  begin
    PRDATA          = prdata_q;
    PREADY          = pready_q;
    PSLVERR         = pslverr_q;
    LINK_PROP.valid = st_q == link_mode_pkg::ST_PROPOSE;
    LINK_PROP.mode  = prop_q;
    LINK_ACK        = ack_q;
    MODE_STATUS     = cur_q;
    TRAFFIC_EN      = en_q;
    SERIAL_TICK     = tick_q;
  end

  // checks
  property p_serial_only_gate;
    @(posedge CLOCK) disable iff (!RESET_N)
    cur_q == link_mode_pkg::MODE_SERIAL_ONLY_LP |-> TRAFFIC_EN == 5'b00001;
  endproperty
  a_serial_only_gate: assert property (p_serial_only_gate) else $error("serial-only mode leaks traffic");

  property p_serial_net_gate;
    @(posedge CLOCK) disable iff (!RESET_N)
    cur_q == link_mode_pkg::MODE_SERIAL_NET_LP |-> TRAFFIC_EN == 5'b00101;
  endproperty
  a_serial_net_gate: assert property (p_serial_net_gate) else $error("serial-net mode gating wrong");

  property p_lp_priority;
    @(posedge CLOCK) disable iff (!RESET_N)
    (!both_auto && (loc_mode_q == link_mode_pkg::MODE_SERIAL_ONLY_LP
     || rem_mode == link_mode_pkg::MODE_SERIAL_ONLY_LP)) |-> target == link_mode_pkg::MODE_SERIAL_ONLY_LP;
  endproperty
  a_lp_priority: assert property (p_lp_priority) else $error("serial-only end did not win");

  property p_manual_apply;
    @(posedge CLOCK) disable iff (!RESET_N)
    (st_q == link_mode_pkg::ST_IDLE && pend_q && both_manual && !REMOTE_PROP.valid)
    |=> cur_q == $past(target);
  endproperty
  a_manual_apply: assert property (p_manual_apply) else $error("manual pair not applied");

  property p_auto_video;
    @(posedge CLOCK) disable iff (!RESET_N)
    both_auto && REMOTE_VIDEO |-> target == link_mode_pkg::MODE_FULL_BANDWIDTH;
  endproperty
  a_auto_video: assert property (p_auto_video) else $error("auto with video not full");

  property p_auto_novideo;
    @(posedge CLOCK) disable iff (!RESET_N)
    both_auto && !REMOTE_VIDEO |-> target inside {link_mode_pkg::MODE_SERIAL_ONLY_LP,
                                                  link_mode_pkg::MODE_SERIAL_NET_LP};
  endproperty
  a_auto_novideo: assert property (p_auto_novideo) else $error("auto without video not low power");

  property p_no_long_auto;
    @(posedge CLOCK) disable iff (!RESET_N)
    (both_auto && st_q == link_mode_pkg::ST_IDLE && REMOTE_PROP.valid
     && REMOTE_PROP.mode == link_mode_pkg::MODE_LONG_REACH) |=> cur_q == $past(cur_q) && !LINK_ACK;
  endproperty
  a_no_long_auto: assert property (p_no_long_auto) else $error("long reach taken with both auto");

  property p_follow_only_leader;
    @(posedge CLOCK) disable iff (!RESET_N)
    $rose(LINK_ACK) |-> $past(rem_leads) && cur_q == $past(REMOTE_PROP.mode);
  endproperty
  a_follow_only_leader: assert property (p_follow_only_leader) else $error("followed a non-leader");

  property p_propose_commit;
    @(posedge CLOCK) disable iff (!RESET_N)
    (LINK_PROP.valid && REMOTE_ACK) |=> cur_q == $past(prop_q) && !LINK_PROP.valid;
  endproperty
  a_propose_commit: assert property (p_propose_commit) else $error("acked proposal not applied");

  property p_propose_role;
    @(posedge CLOCK) disable iff (!RESET_N)
    $rose(LINK_PROP.valid) |-> $past(loc_leads) ##1 LINK_PROP.mode == $past(LINK_PROP.mode);
  endproperty
  a_propose_role: assert property (p_propose_role) else $error("proposal without manual lead");

  property p_no_unilateral;
    @(posedge CLOCK) disable iff (!RESET_N)
    (cur_q != $past(cur_q) && !$past(both_manual)) |-> LINK_ACK || $past(REMOTE_ACK);
  endproperty
  a_no_unilateral: assert property (p_no_unilateral) else $error("mode changed unilaterally");

  property p_status_tracks;
    @(posedge CLOCK) disable iff (!RESET_N)
    changed |=> pend_q || st_q != link_mode_pkg::ST_IDLE || $past(REMOTE_PROP.valid);
  endproperty
  a_status_tracks: assert property (p_status_tracks) else $error("change not re-evaluated");

  c_auto_full: cover property (@(posedge CLOCK) disable iff (!RESET_N)
    both_auto && LINK_ACK && cur_q == link_mode_pkg::MODE_FULL_BANDWIDTH);
  c_local_lead: cover property (@(posedge CLOCK) disable iff (!RESET_N)
    LINK_PROP.valid ##1 REMOTE_ACK);
  c_refused: cover property (@(posedge CLOCK) disable iff (!RESET_N) $rose(refused_q));

endmodule : link_mode_resolver

/* File: verilog/mode_table.sv */
// Purpose: combine both ends' configured modes into a target mode
// Assumes: remote mode already sanitised to a legal code
// Notes:   purely combinational
`timescale 1ns/1ps
module mode_table (
  input  link_mode_pkg::mode_e loc_mode,
  input  link_mode_pkg::mode_e rem_mode,
  input  wire logic            video_present,
  input  wire logic            lp_serial_only,
  output link_mode_pkg::mode_e target
);

  always_comb
  begin
    if (loc_mode == link_mode_pkg::MODE_AUTO && rem_mode == link_mode_pkg::MODE_AUTO)
    begin
      // long reach is never an outcome here
      if (video_present)
        target = link_mode_pkg::MODE_FULL_BANDWIDTH;
      else if (lp_serial_only)
        target = link_mode_pkg::MODE_SERIAL_ONLY_LP;
      else
        target = link_mode_pkg::MODE_SERIAL_NET_LP;
    end
    else if (loc_mode == link_mode_pkg::MODE_SERIAL_ONLY_LP || rem_mode == link_mode_pkg::MODE_SERIAL_ONLY_LP)
      target = link_mode_pkg::MODE_SERIAL_ONLY_LP;
    else if (loc_mode == link_mode_pkg::MODE_SERIAL_NET_LP || rem_mode == link_mode_pkg::MODE_SERIAL_NET_LP)
      target = link_mode_pkg::MODE_SERIAL_NET_LP;
    else if (loc_mode == link_mode_pkg::MODE_LONG_REACH || rem_mode == link_mode_pkg::MODE_LONG_REACH)
      target = link_mode_pkg::MODE_LONG_REACH;
    else
      target = link_mode_pkg::MODE_FULL_BANDWIDTH;
  end

endmodule : mode_table
